// ==== mcu_exec_pkg.sv ====
// Constants, opcodes and state type for the instruction execution core
package mcu_exec_pkg;
  // Machine widths
  localparam int PC_WIDTH = 11;
  localparam int INSTR_WIDTH = 14;
  localparam int DATA_WIDTH = 8;
  // Four system clocks per instruction cycle
  localparam logic [1:0] PHASE_FIRST = 2'h0;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  // Data memory address of the program-counter low byte
  localparam logic [7:0] PCL_ADDR = 8'h06;
  // Upper three address bits of the last program page
  localparam logic [2:0] LAST_PAGE = 3'h7;
  // BCD nibble limit and adjustment
  localparam logic [4:0] BCD_LIMIT = 5'h09;
  localparam logic [4:0] BCD_ADJUST = 5'h06;
  // Reset values
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [PC_WIDTH-1:0] PC_RESET = 11'h000;
  localparam logic [5:0] HIGH_ZERO = 6'h00;
  // Opcode field positions
  localparam int OP_MSB = 13;
  localparam int OP_LSB = 8;
  // Six-bit opcodes (bits 13:8)
  localparam logic [5:0] OP_NOP = 6'h00;
  localparam logic [5:0] OP_ADD_M = 6'h01;
  localparam logic [5:0] OP_ADD_TO_MEMORY_INSTR = 6'h02;
  localparam logic [5:0] OP_ADD_X = 6'h03;
  localparam logic [5:0] OP_ADC_M = 6'h04;
  localparam logic [5:0] OP_ADCM = 6'h05;
  localparam logic [5:0] OP_AND_M = 6'h06;
  localparam logic [5:0] OP_AND_TO_MEMORY_INSTR = 6'h07;
  localparam logic [5:0] OP_AND_X = 6'h08;
  localparam logic [5:0] OP_CPL = 6'h09;
  localparam logic [5:0] OP_COMPLEMENT_TO_ACCUMULATOR_INSTR = 6'h0a;
  localparam logic [5:0] OP_DAA = 6'h0b;
  localparam logic [5:0] OP_INC = 6'h0c;
  localparam logic [5:0] OP_INCREMENT_TO_ACCUMULATOR = 6'h0d;
  localparam logic [5:0] OP_DEC = 6'h0e;
  localparam logic [5:0] OP_DECREMENT_TO_ACCUMULATOR = 6'h0f;
  localparam logic [5:0] OP_CLR_M = 6'h10;
  localparam logic [5:0] OP_SET_M = 6'h11;
  localparam logic [5:0] OP_SWAP = 6'h12;
  localparam logic [5:0] OP_NIBBLE_SWAP_TO_ACCUMULATOR = 6'h13;
  localparam logic [5:0] OP_WDT_CLR = 6'h14;
  localparam logic [5:0] OP_WDT_PRE1 = 6'h15;
  localparam logic [5:0] OP_WDT_PRE2 = 6'h16;
  localparam logic [5:0] OP_HALT = 6'h17;
  localparam logic [5:0] OP_TBL_CUR = 6'h18;
  localparam logic [5:0] OP_TBL_LAST = 6'h19;
  localparam logic [5:0] OP_SKIP_ZERO = 6'h1a;
  // Bit clear: bits 13:11 = 100, bit index in bits 10:8
  localparam logic [2:0] OP_BIT_CLR = 3'h4;
  // Call and jump: bits 13:11, target in bits 10:0
  localparam logic [2:0] OP_CALL = 3'h6;
  localparam logic [2:0] OP_JUMP = 3'h7;
  // Sequencer states, Gray coded along exec -> extra -> table -> halt
  typedef enum logic [1:0] {
    ST_EXEC = 2'h0,
    ST_EXTRA = 2'h1,
    ST_TABLE = 2'h3,
    ST_HALT = 2'h2
  } state_type;
endpackage

// ==== mcu_instruction_execute.sv ====
// Instruction execution core: table read, watchdog, halt, ALU, branch
// Operation
// - Current-page table read: two cycles, low/high
// - Last-page table read: two cycles, low/high
// - Writing program-counter low byte adds one cycle
// - Taken skip discards next, adds dummy cycle
// - Watchdog clear zeroes counters and both flags
// - Pre-clear pair clears only after partner
// - Halt stops, clears watchdog, sets powerdown
// - Add, optional carry, to accumulator or memory
// - AND to accumulator or memory
// - Call pushes PC+1, loads target
// - Clear bit or whole byte of memory
// - Complement to memory or accumulator
// - Decimal adjust low then high nibble
// - Adjusted byte to memory, only carry changes
// - Decrement to memory or accumulator
// - Increment to memory or accumulator
// - Jump loads encoded target unconditionally
// - Nibble swap in one cycle
// - Add sets Z,C,AC,OV; logic sets Z
`timescale 1ns/100ps
`default_nettype none
module mcu_instruction_execute #(
  parameter int STACK_DEPTH = 4,  // Return stack levels
  parameter int PRESCALE_WIDTH = 8,  // Watchdog prescaler width
  parameter int WATCHDOG_WIDTH = 8  // Watchdog counter width
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [13:0] rom_data,  // Program ROM word at rom_addr
  input wire logic [7:0] ram_rdata,  // Data memory byte at ram_addr
  input wire logic [7:0] table_pointer,  // Low address byte for table reads
  input wire logic wake_up,  // Leaves power-down
  output logic [10:0] rom_addr,
  output logic [7:0] ram_addr,
  output logic [7:0] ram_wdata,
  output logic ram_we,
  output logic [7:0] accumulator,
  output logic carry_flag,
  output logic zero_flag,
  output logic aux_carry_flag,
  output logic overflow_flag,
  output logic timeout_flag,
  output logic powerdown_flag,
  output logic [5:0] table_high_byte,
  output logic clock_stopped,  // High while halted; clk is not gated and the watchdog keeps counting
  output logic [WATCHDOG_WIDTH-1:0] watchdog_counter
);
  localparam int SP_WIDTH = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;
  localparam logic [PRESCALE_WIDTH-1:0] PRESCALE_MAX = '1;
  localparam logic [WATCHDOG_WIDTH-1:0] WATCHDOG_MAX = '1;

  // Phase within the four-clock instruction cycle
  logic [1:0] phase;
  logic [1:0] next_phase;
  // Sequencer
  mcu_exec_pkg::state_type state;
  mcu_exec_pkg::state_type next_state;
  // Program counter and latched instruction
  logic [10:0] pc;
  logic [10:0] next_pc;
  logic [13:0] instr;
  logic [13:0] next_instr;
  // Return stack, grows upward
  logic [10:0] stack [STACK_DEPTH];
  logic [10:0] next_stack [STACK_DEPTH];
  logic [SP_WIDTH-1:0] sp;
  logic [SP_WIDTH-1:0] next_sp;
  // Watchdog prescaler and pre-clear records
  logic [PRESCALE_WIDTH-1:0] prescale;
  logic [PRESCALE_WIDTH-1:0] next_prescale;
  logic pre1_seen;
  logic next_pre1_seen;
  logic pre2_seen;
  logic next_pre2_seen;
  // Next values of registered outputs
  logic [10:0] next_rom_addr;
  logic [7:0] next_ram_addr;
  logic [7:0] next_ram_wdata;
  logic next_ram_we;
  logic [7:0] next_acc;
  logic next_c;
  logic next_z;
  logic next_ac;
  logic next_ov;
  logic next_to;
  logic next_pd;
  logic [5:0] next_tbl_high;
  logic [WATCHDOG_WIDTH-1:0] next_wdt;

  // Add with carry: result, carry from bit 7 and bit 3, overflow
  function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [8:0] sum;
    logic [4:0] low;
    sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    add8 = {sum[8], low[4], (a[7] == b[7]) && (sum[7] != a[7]), sum[7:0]};
  endfunction

  // Phase counter: free running, one instruction cycle per wrap
  always_comb begin
    next_phase = phase + 2'h1;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase <= mcu_exec_pkg::PHASE_FIRST;
    end else begin
      phase <= next_phase;
    end
  end

  // Next-state logic of the core
  always_comb begin
    logic [5:0] op;
    logic [10:0] sum;
    logic [7:0] result;
    logic wr_mem;
    logic wr_acc;
    logic upd_z;
    logic upd_add;
    logic wdt_clear;
    logic extra;
    logic [4:0] lo_t;
    logic [4:0] hi_t;
    logic nib_carry;
    op = instr[mcu_exec_pkg::OP_MSB:mcu_exec_pkg::OP_LSB];
    sum = '0;
    result = mcu_exec_pkg::BYTE_ZERO;
    wr_mem = 1'b0;
    wr_acc = 1'b0;
    upd_z = 1'b0;
    upd_add = 1'b0;
    wdt_clear = 1'b0;
    extra = 1'b0;
    lo_t = 5'h00;
    hi_t = 5'h00;
    nib_carry = 1'b0;
    next_state = state;
    next_pc = pc;
    next_instr = instr;
    next_stack = stack;
    next_sp = sp;
    next_pre1_seen = pre1_seen;
    next_pre2_seen = pre2_seen;
    next_rom_addr = rom_addr;
    next_ram_addr = ram_addr;
    next_ram_wdata = ram_wdata;
    next_ram_we = 1'b0;
    next_acc = accumulator;
    next_c = carry_flag;
    next_z = zero_flag;
    next_ac = aux_carry_flag;
    next_ov = overflow_flag;
    next_to = timeout_flag;
    next_pd = powerdown_flag;
    next_tbl_high = table_high_byte;
    // Watchdog keeps counting in every state, including power-down
    next_prescale = prescale + {{(PRESCALE_WIDTH-1){1'b0}}, 1'b1};
    next_wdt = watchdog_counter;
    if (prescale == PRESCALE_MAX) begin
      next_wdt = watchdog_counter + {{(WATCHDOG_WIDTH-1){1'b0}}, 1'b1};
    end
    unique case (state)
      mcu_exec_pkg::ST_EXEC: begin
        // Latch the instruction and its operand address
        if (phase == mcu_exec_pkg::PHASE_FIRST) begin
          next_instr = rom_data;
          next_ram_addr = rom_data[7:0];
        end
        if (phase == mcu_exec_pkg::PHASE_LAST) begin
          next_pc = pc + 11'h001;
          if (instr[13:11] == mcu_exec_pkg::OP_JUMP) begin
            next_pc = instr[10:0];
            extra = 1'b1;
          end else if (instr[13:11] == mcu_exec_pkg::OP_CALL) begin
            next_stack[sp] = pc + 11'h001;
            next_sp = sp + {{(SP_WIDTH-1){1'b0}}, 1'b1};
            next_pc = instr[10:0];
            extra = 1'b1;
          end else if (instr[13:11] == mcu_exec_pkg::OP_BIT_CLR) begin
            result = ram_rdata & ~(8'h01 << instr[10:8]);
            wr_mem = 1'b1;
          end else begin
            case (op)
              mcu_exec_pkg::OP_ADD_M, mcu_exec_pkg::OP_ADD_TO_MEMORY_INSTR: begin
                sum = add8(accumulator, ram_rdata, 1'b0);
                upd_add = 1'b1;
                wr_mem = (op == mcu_exec_pkg::OP_ADD_TO_MEMORY_INSTR);
                wr_acc = !wr_mem;
              end
              mcu_exec_pkg::OP_ADD_X: begin
                sum = add8(accumulator, instr[7:0], 1'b0);
                upd_add = 1'b1;
                wr_acc = 1'b1;
              end
              mcu_exec_pkg::OP_ADC_M, mcu_exec_pkg::OP_ADCM: begin
                sum = add8(accumulator, ram_rdata, carry_flag);
                upd_add = 1'b1;
                wr_mem = (op == mcu_exec_pkg::OP_ADCM);
                wr_acc = !wr_mem;
              end
              mcu_exec_pkg::OP_AND_M, mcu_exec_pkg::OP_AND_TO_MEMORY_INSTR: begin
                result = accumulator & ram_rdata;
                upd_z = 1'b1;
                wr_mem = (op == mcu_exec_pkg::OP_AND_TO_MEMORY_INSTR);
                wr_acc = !wr_mem;
              end
              mcu_exec_pkg::OP_AND_X: begin
                result = accumulator & instr[7:0];
                upd_z = 1'b1;
                wr_acc = 1'b1;
              end
              mcu_exec_pkg::OP_CPL, mcu_exec_pkg::OP_COMPLEMENT_TO_ACCUMULATOR_INSTR: begin
                result = ~ram_rdata;
                upd_z = 1'b1;
                wr_mem = (op == mcu_exec_pkg::OP_CPL);
                wr_acc = !wr_mem;
              end
              mcu_exec_pkg::OP_INC, mcu_exec_pkg::OP_INCREMENT_TO_ACCUMULATOR: begin
                result = ram_rdata + 8'h01;
                upd_z = 1'b1;
                wr_mem = (op == mcu_exec_pkg::OP_INC);
                wr_acc = !wr_mem;
              end
              mcu_exec_pkg::OP_DEC, mcu_exec_pkg::OP_DECREMENT_TO_ACCUMULATOR: begin
                result = ram_rdata - 8'h01;
                upd_z = 1'b1;
                wr_mem = (op == mcu_exec_pkg::OP_DEC);
                wr_acc = !wr_mem;
              end
              mcu_exec_pkg::OP_DAA: begin
                // Low nibble, then high with internal carry
                lo_t = {1'b0, accumulator[3:0]};
                if ((lo_t > mcu_exec_pkg::BCD_LIMIT) || aux_carry_flag) begin
                  lo_t = lo_t + mcu_exec_pkg::BCD_ADJUST;
                  nib_carry = lo_t[4];
                end
                hi_t = {1'b0, accumulator[7:4]} + {4'h0, nib_carry};
                if ((hi_t > mcu_exec_pkg::BCD_LIMIT) || carry_flag) begin
                  hi_t = hi_t + mcu_exec_pkg::BCD_ADJUST;
                  next_c = 1'b1;
                end
                result = {hi_t[3:0], lo_t[3:0]};
                wr_mem = 1'b1;
              end
              mcu_exec_pkg::OP_CLR_M: begin
                result = mcu_exec_pkg::BYTE_ZERO;
                wr_mem = 1'b1;
              end
              mcu_exec_pkg::OP_SET_M: begin
                result = ~mcu_exec_pkg::BYTE_ZERO;
                wr_mem = 1'b1;
              end
              mcu_exec_pkg::OP_SWAP, mcu_exec_pkg::OP_NIBBLE_SWAP_TO_ACCUMULATOR: begin
                result = {ram_rdata[3:0], ram_rdata[7:4]};
                wr_mem = (op == mcu_exec_pkg::OP_SWAP);
                wr_acc = !wr_mem;
              end
              mcu_exec_pkg::OP_WDT_CLR: begin
                wdt_clear = 1'b1;
              end
              mcu_exec_pkg::OP_WDT_PRE1: begin
                wdt_clear = pre2_seen;
                next_pre1_seen = !pre2_seen;
              end
              mcu_exec_pkg::OP_WDT_PRE2: begin
                wdt_clear = pre1_seen;
                next_pre2_seen = !pre1_seen;
              end
              mcu_exec_pkg::OP_HALT: begin
                wdt_clear = 1'b1;
                next_state = mcu_exec_pkg::ST_HALT;
              end
              mcu_exec_pkg::OP_TBL_CUR: begin
                next_state = mcu_exec_pkg::ST_TABLE;
              end
              mcu_exec_pkg::OP_TBL_LAST: begin
                next_state = mcu_exec_pkg::ST_TABLE;
              end
              mcu_exec_pkg::OP_SKIP_ZERO: begin
                // Taken skip passes over next word
                if (ram_rdata == mcu_exec_pkg::BYTE_ZERO) begin
                  next_pc = pc + 11'h002;
                  extra = 1'b1;
                end
              end
              default: begin
                // No operation
              end
            endcase
          end
          // Truncated sum, carries from bits 7 and 3
          if (upd_add) begin
            result = sum[7:0];
            next_c = sum[10];
            next_ac = sum[9];
            next_ov = sum[8];
            upd_z = 1'b1;
          end
          if (upd_z) begin
            next_z = (result == mcu_exec_pkg::BYTE_ZERO);
          end
          if (wr_acc) begin
            next_acc = result;
          end
          if (wr_mem) begin
            next_ram_wdata = result;
            next_ram_we = 1'b1;
            if (ram_addr == mcu_exec_pkg::PCL_ADDR) begin
              next_pc = {pc[10:8], result};
              extra = 1'b1;
            end
          end
          if (wdt_clear) begin
            next_prescale = '0;
            next_wdt = '0;
            next_to = 1'b0;
            next_pd = 1'b0;
            next_pre1_seen = 1'b0;
            next_pre2_seen = 1'b0;
          end
          if (op == mcu_exec_pkg::OP_HALT && instr[13:11] != mcu_exec_pkg::OP_BIT_CLR) begin
            next_pd = 1'b1;
          end
          if (extra) begin
            next_state = mcu_exec_pkg::ST_EXTRA;
          end
          next_rom_addr = next_pc;
          // Table address replaces the fetch address for one cycle
          if (next_state == mcu_exec_pkg::ST_TABLE) begin
            next_rom_addr = (op == mcu_exec_pkg::OP_TBL_LAST) ? {mcu_exec_pkg::LAST_PAGE, table_pointer}
                                                                : {pc[10:8], table_pointer};
          end
        end
      end
      mcu_exec_pkg::ST_EXTRA: begin
        // Dummy cycle: the fetch is discarded
        if (phase == mcu_exec_pkg::PHASE_LAST) begin
          next_state = mcu_exec_pkg::ST_EXEC;
        end
      end
      mcu_exec_pkg::ST_TABLE: begin
        // Second cycle: split word into memory and high register
        if (phase == mcu_exec_pkg::PHASE_LAST) begin
          next_ram_wdata = rom_data[7:0];
          next_ram_we = 1'b1;
          next_tbl_high = rom_data[13:8];
          next_state = mcu_exec_pkg::ST_EXEC;
          next_rom_addr = pc;
          // Table data landing in the low byte
          if (ram_addr == mcu_exec_pkg::PCL_ADDR) begin
            next_pc = {pc[10:8], rom_data[7:0]};
            next_rom_addr = next_pc;
            next_state = mcu_exec_pkg::ST_EXTRA;
          end
        end
      end
      mcu_exec_pkg::ST_HALT: begin
        // Registers other than the watchdog hold; resume at a cycle boundary after wake-up
        if (wake_up && phase == mcu_exec_pkg::PHASE_LAST) begin
          next_state = mcu_exec_pkg::ST_EXEC;
        end
      end
    endcase
    // Watchdog expiry sets time-out, except when a clear lands in the same cycle
    if (prescale == PRESCALE_MAX && watchdog_counter == WATCHDOG_MAX && !wdt_clear) begin
      next_to = 1'b1;
    end
  end

  // Core registers; stack is not reset beyond a known value
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= mcu_exec_pkg::ST_EXEC;
      pc <= mcu_exec_pkg::PC_RESET;
      instr <= '0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack[i] <= mcu_exec_pkg::PC_RESET;
      end
      sp <= '0;
      prescale <= '0;
      pre1_seen <= 1'b0;
      pre2_seen <= 1'b0;
      rom_addr <= mcu_exec_pkg::PC_RESET;
      ram_addr <= mcu_exec_pkg::BYTE_ZERO;
      ram_wdata <= mcu_exec_pkg::BYTE_ZERO;
      ram_we <= 1'b0;
      accumulator <= mcu_exec_pkg::BYTE_ZERO;
      carry_flag <= 1'b0;
      zero_flag <= 1'b0;
      aux_carry_flag <= 1'b0;
      overflow_flag <= 1'b0;
      timeout_flag <= 1'b0;
      powerdown_flag <= 1'b0;
      table_high_byte <= mcu_exec_pkg::HIGH_ZERO;
      clock_stopped <= 1'b0;
      watchdog_counter <= '0;
    end else begin
      state <= next_state;
      pc <= next_pc;
      instr <= next_instr;
      stack <= next_stack;
      sp <= next_sp;
      prescale <= next_prescale;
      pre1_seen <= next_pre1_seen;
      pre2_seen <= next_pre2_seen;
      rom_addr <= next_rom_addr;
      ram_addr <= next_ram_addr;
      ram_wdata <= next_ram_wdata;
      ram_we <= next_ram_we;
      accumulator <= next_acc;
      carry_flag <= next_c;
      zero_flag <= next_z;
      aux_carry_flag <= next_ac;
      overflow_flag <= next_ov;
      timeout_flag <= next_to;
      powerdown_flag <= next_pd;
      table_high_byte <= next_tbl_high;
      clock_stopped <= (next_state == mcu_exec_pkg::ST_HALT);
      watchdog_counter <= next_wdt;
    end
  end
endmodule // mcu_instruction_execute
`default_nettype wire

// ==== mcu_instruction_execute_assertions.sv ====
// Concurrent checks on the ports of the instruction execution core
`timescale 1ns/100ps
`default_nettype none
module mcu_instruction_execute_assertions #(
  parameter int WATCHDOG_WIDTH = 8  // Width of the watched counter
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ram_we,
  input wire logic [7:0] accumulator,
  input wire logic carry_flag,
  input wire logic timeout_flag,
  input wire logic powerdown_flag,
  input wire logic [5:0] table_high_byte,
  input wire logic clock_stopped,
  input wire logic [WATCHDOG_WIDTH-1:0] watchdog_counter
);
  // One clock domain, so clocking and reset are declared once
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_we_spacing: assert property (ram_we |=> !ram_we [*3])
    else $error("Data memory written twice in one instruction cycle");
  chk_acc_spacing: assert property ($changed(accumulator) |=> $stable(accumulator) [*3])
    else $error("Accumulator changed inside an instruction cycle");
  chk_carry_spacing: assert property ($changed(carry_flag) |=> $stable(carry_flag) [*3])
    else $error("Carry changed inside an instruction cycle");
  chk_table_write: assert property ($changed(table_high_byte) |-> ram_we)
    else $error("Table high part loaded without the low byte write");
  chk_table_spacing: assert property ($changed(table_high_byte) |=> $stable(table_high_byte) [*7])
    else $error("Table reads closer than two instruction cycles");
  chk_halt_flags: assert property ($rose(clock_stopped) |-> powerdown_flag && !timeout_flag && watchdog_counter == '0)
    else $error("Power-down entry left flags or watchdog wrong");
  chk_halt_quiet: assert property (clock_stopped |-> !ram_we)
    else $error("Data memory written while halted");
  chk_wdt_clear: assert property ($fell(powerdown_flag) |-> !timeout_flag && watchdog_counter == '0)
    else $error("Power-down flag cleared without a watchdog clear");
endmodule // mcu_instruction_execute_assertions
bind mcu_instruction_execute mcu_instruction_execute_assertions #(
  .WATCHDOG_WIDTH(WATCHDOG_WIDTH)
) i_mcu_instruction_execute_assertions (
  .clk(clk),
  .sys_rst(sys_rst),
  .ram_we(ram_we),
  .accumulator(accumulator),
  .carry_flag(carry_flag),
  .timeout_flag(timeout_flag),
  .powerdown_flag(powerdown_flag),
  .table_high_byte(table_high_byte),
  .clock_stopped(clock_stopped),
  .watchdog_counter(watchdog_counter)
);
`default_nettype wire

// ==== mcu_mem_model.sv ====
// Program ROM and data memory facing the execution core
`timescale 1ns/100ps
`default_nettype none
module mcu_mem_model (
  input wire logic clk,
  input wire logic [10:0] rom_addr,
  input wire logic [7:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  input wire logic ram_we,
  output logic [13:0] rom_data,
  output logic [7:0] ram_rdata
);
  logic [13:0] rom [0:2047];  // Program words, loaded by the bench
  logic [7:0] ram [0:255];  // Data bytes, preset by the bench
  // word lookup
  // Reads are asynchronous: the core samples them one or more clocks after the address
  assign rom_data = rom[rom_addr];
  assign ram_rdata = ram[ram_addr];
  // Plain always so the bench may also preset bytes between runs
  always @(posedge clk) begin
    if (ram_we) begin
      ram[ram_addr] <= ram_wdata;
    end
  end
endmodule // mcu_mem_model
`default_nettype wire

// ==== test_mcu_instruction_execute.sv ====
// Self-checking bench for the instruction execution core
`timescale 1ns/100ps
`default_nettype none
`define CHECK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("Error at %0t: got %h, expected %h", $time, (got), (exp)); \
    end \
  end
module test_mcu_instruction_execute;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wake_up = 1'b0;
  logic [7:0] table_pointer = 8'h80;  // Held: table words sit at offset 80
  logic [13:0] rom_data;
  logic [7:0] ram_rdata, ram_addr, ram_wdata, accumulator;
  logic [10:0] rom_addr;
  logic ram_we, carry_flag, zero_flag, aux_carry_flag, overflow_flag;
  logic timeout_flag, powerdown_flag, clock_stopped;
  logic [5:0] table_high_byte;
  logic [1:0] watchdog_counter;  // Matches the shrunk watchdog below
  int error_cnt = 0;
  int tests_run = 0;
  time t_first;
  // Watchdog shrunk to sixteen clocks so time-out really rises before the first halt and the single clear
  mcu_instruction_execute #(.PRESCALE_WIDTH(2), .WATCHDOG_WIDTH(2)) i_mcu_instruction_execute (.clk(clk),
    .sys_rst(sys_rst), .rom_data(rom_data),
    .ram_rdata(ram_rdata), .table_pointer(table_pointer), .wake_up(wake_up), .rom_addr(rom_addr),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_we(ram_we), .accumulator(accumulator),
    .carry_flag(carry_flag), .zero_flag(zero_flag), .aux_carry_flag(aux_carry_flag),
    .overflow_flag(overflow_flag), .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
    .table_high_byte(table_high_byte), .clock_stopped(clock_stopped), .watchdog_counter(watchdog_counter));
  mcu_mem_model i_mcu_mem_model (.clk(clk), .rom_addr(rom_addr), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .ram_we(ram_we), .rom_data(rom_data), .ram_rdata(ram_rdata));
  // 50 MHz system clock
  initial begin
    forever #10 clk = ~clk;
  end
  // Verdict and end of run
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Holds reset and empties both memories
  task automatic clear();
    @(negedge clk);
    sys_rst = 1'b1;
    for (int i = 0; i < 2048; i++) i_mcu_mem_model.rom[i] = 14'h0000;
    for (int i = 0; i < 256; i++) i_mcu_mem_model.ram[i] = 8'h00;
  endtask
  // Stores a program word and presets the byte its operand points at
  task automatic put(input int i, input logic [13:0] w, input logic [7:0] v);
    i_mcu_mem_model.rom[i] = w;
    i_mcu_mem_model.ram[w[7:0]] = v;
  endtask
  // Reset stays up eight cycles so the program is in place first
  task automatic go();
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
  endtask
  task automatic ck(input logic [7:0] a, input logic [7:0] v);
    `CHECK(i_mcu_mem_model.ram[a], v);
  endtask
  // Bounded wait for the next write pulse
  task automatic wait_we();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (ram_we !== 1'b1 && n < 400);
    if (n >= 400) begin
      error_cnt++;
      stop_test();
    end
  endtask
  // Bounded wait for the halt state to reach a level
  task automatic wait_cs(input logic v);
    int n;
    n = 0;
    while (clock_stopped !== v && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n >= 400) begin
      error_cnt++;
      stop_test();
    end
  endtask
  // Arithmetic, logic and memory-operand chain; acc value threads through the add, AND and DAA steps
  task automatic test_alu();
    clear();
    put(0, 14'h038f, 8'h00); put(1, 14'h0220, 8'h71); put(2, 14'h0521, 8'h10);
    put(3, 14'h0c22, 8'hff); put(4, 14'h0f23, 8'h00); put(5, 14'h0724, 8'h3c);
    put(6, 14'h0925, 8'h5a); put(7, 14'h1226, 8'h12); put(8, 14'h2327, 8'hff);
    put(9, 14'h1028, 8'h77); put(10, 14'h089a, 8'h00); put(11, 14'h0b29, 8'h55);
    put(12, 14'h132b, 8'hc3); put(13, 14'h0a2c, 8'hf0); put(14, 14'h0d2d, 8'h41);
    put(15, 14'h062e, 8'h0f); put(16, 14'h012f, 8'h7f); put(17, 14'h0e30, 8'h00);
    put(18, 14'h1131, 8'h00);
    go();
    repeat (100) @(negedge clk);
    ck(8'h20, 8'h00);
    ck(8'h21, 8'ha0);
    ck(8'h22, 8'h00);
    ck(8'h23, 8'h00);
    ck(8'h24, 8'h3c);
    ck(8'h25, 8'ha5);
    ck(8'h26, 8'h21);
    ck(8'h27, 8'hf7);
    ck(8'h28, 8'h00);
    ck(8'h29, 8'h00);
    ck(8'h2b, 8'hc3);
    ck(8'h2c, 8'hf0);
    ck(8'h2d, 8'h41);
    ck(8'h30, 8'hff);
    `CHECK(accumulator, 8'h81);
    `CHECK({carry_flag, aux_carry_flag, overflow_flag, zero_flag}, 4'h6);
    $display("alu test done");
  endtask
  // Taken skip, jump, call, low-byte write, untaken skip; write spacing shows dummy cycles
  task automatic test_branch();
    clear();
    put(0, 14'h0c35, 8'h00); put(1, 14'h1a32, 8'h00); put(2, 14'h0c33, 8'h00);
    put(3, 14'h3810, 8'h00); put(16, 14'h3020, 8'h00); put(32, 14'h0c30, 8'h00);
    // Increment of the low byte sends execution to 28 hex, then an untaken skip
    put(33, 14'h0c06, 8'h27);
    put(40, 14'h1a37, 8'h05);
    put(41, 14'h0c36, 8'h00);
    go();
    wait_we();
    t_first = $time;
    `CHECK(ram_addr, 8'h35);
    wait_we();
    `CHECK(ram_addr, 8'h30);
    `CHECK($time - t_first, 64'h230);
    wait_we();
    `CHECK({ram_addr, ram_wdata}, 16'h0628);
    t_first = $time;
    wait_we();
    `CHECK(ram_addr, 8'h36);
    `CHECK($time - t_first, 64'hf0);
    $display("branch test done");
  endtask
  // Table reads, power-down, pre-clear pair and single clear
  task automatic test_system();
    clear();
    put(0, 14'h1840, 8'h00); put(1, 14'h1941, 8'h00); put(2, 14'h1700, 8'h00);
    put(3, 14'h1500, 8'h00); put(4, 14'h0c42, 8'h01); put(5, 14'h1600, 8'h00);
    put(6, 14'h0c43, 8'h01); put(7, 14'h1700, 8'h00); put(8, 14'h1400, 8'h00);
    put(9, 14'h0c44, 8'h01);
    i_mcu_mem_model.rom[11'h080] = 14'h2a55;
    i_mcu_mem_model.rom[11'h780] = 14'h1234;
    go();
    wait_we();
    `CHECK({table_high_byte, ram_addr, ram_wdata}, 22'h2a4055);
    wait_we();
    `CHECK({table_high_byte, ram_addr, ram_wdata}, 22'h124134);
    wait_cs(1'b1);
    // Time-out had risen before the halt, so this shows it cleared
    `CHECK({powerdown_flag, timeout_flag, watchdog_counter}, 4'h8);
    wake_up = 1'b1;
    wait_cs(1'b0);
    wake_up = 1'b0;
    wait_we();
    `CHECK(powerdown_flag, 1'b1);
    wait_we();
    `CHECK({powerdown_flag, timeout_flag}, 2'h0);
    wait_cs(1'b1);
    // Stay halted until the watchdog raises time-out, so the clear has work
    repeat (20) @(negedge clk);
    `CHECK({powerdown_flag, timeout_flag}, 2'h3);
    wake_up = 1'b1;
    wait_cs(1'b0);
    wake_up = 1'b0;
    wait_we();
    `CHECK({powerdown_flag, timeout_flag, ram_addr}, 10'h044);
    $display("system test done");
  endtask
  initial begin
    test_alu();
    test_branch();
    test_system();
    stop_test();
  end
endmodule // test_mcu_instruction_execute
`default_nettype wire
